/* hw/sarc_regs.vh */
`ifndef SARC_REGS_VH
`define SARC_REGS_VH
// ****************************************************************
// timing in nanoseconds and derived cycle counts at 40 MHz (25 ns)
// ****************************************************************
`define SARC_CLK_NS          25
`define SARC_CONV_PULSE_NS   40
`define SARC_CONV_PULSE_CYC  ((`SARC_CONV_PULSE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_BUSY_MAX_NS     2500
`define SARC_BUSY_MAX_CYC    (`SARC_BUSY_MAX_NS / `SARC_CLK_NS)
`define SARC_BUSY_SETUP_NS   5
`define SARC_BUSY_SETUP_CYC  ((`SARC_BUSY_SETUP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_SEL_SETUP_NS    15
`define SARC_SEL_SETUP_CYC   ((`SARC_SEL_SETUP_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_PHASE_NS        15
`define SARC_PHASE_CYC       ((`SARC_PHASE_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS)
`define SARC_PERIOD_NS       35
// half period of the external bit clock in system cycles: 100 ns period, 50 ns phases
`define SARC_EXT_HALF_CYC    2
`define SARC_WAKE_MS         1
`define SARC_WAKE_CYC        (`SARC_WAKE_MS * 1000000 / `SARC_CLK_NS)
`define SARC_WORD_BITS       16
`define SARC_INT_BITS        16
`endif

/* hw/sarc_clk_div.v */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// half-period enable divider for the external bit clock
// ****************************************************************
module sarc_clk_div #(
  parameter HALF = 2
) (
  input  wire clk,
  input  wire rst,
  input  wire run,
  output reg  tick
);
  reg [7:0] cnt_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (!run) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else if (cnt_reg == HALF[7:0] - 8'h01) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      tick    <= 1'b0;
    end
  end
endmodule // sarc_clk_div
`default_nettype wire

/* hw/sarc_host.v */
`timescale 1ns/10ps
`default_nettype none
`include "sarc_regs.vh"
module sarc_host #(
  parameter CHAIN    = 1,
  parameter WAKE_CYC = `SARC_WAKE_CYC
) (
  input  wire                            clk,
  input  wire                            rst,
  input  wire                            startReq,
  input  wire                            extMode,
  input  wire                            sleepReq,
  input  wire                            busyIn,
  input  wire                            serialResultLine,
  input  wire                            serialBitClockIn,
  output reg                             convReadSel,
  output reg                             chipSelN,
  output reg                             serialBitClockOut,
  output reg                             clockSourceSelect,
  output reg                             analogSleep,
  output reg                             referenceSleep,
  output reg  [`SARC_WORD_BITS*CHAIN-1:0] resultData,
  output reg                             resultValid,
  output reg                             hostIdle,
  output reg                             wakeBusy
);
  localparam NBITS = `SARC_WORD_BITS * CHAIN;
  localparam [2:0] S_IDLE = 3'h0, S_CONV = 3'h1, S_WAITB = 3'h2, S_SETUP = 3'h3,
                   S_SHIFT = 3'h4, S_DONE = 3'h5, S_DRAIN = 3'h6;
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  reg [1:0] busySync_reg;
  reg [1:0] dataSync_reg;
  reg [1:0] iclkSync_reg;
  reg       iclkLast_reg;
  reg       busyLast_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busySync_reg <= 2'h3;
      dataSync_reg <= 2'h0;
      iclkSync_reg <= 2'h0;
      iclkLast_reg <= 1'b0;
      busyLast_reg <= 1'b1;
    end else begin
      busySync_reg <= {busySync_reg[0], busyIn};
      dataSync_reg <= {dataSync_reg[0], serialResultLine};
      iclkSync_reg <= {iclkSync_reg[0], serialBitClockIn};
      iclkLast_reg <= iclkSync_reg[1];
      busyLast_reg <= busySync_reg[1];
    end
  end
  wire busyS    = busySync_reg[1];
  wire busyRise = busyS & ~busyLast_reg;
  wire iclkRise = iclkSync_reg[1] & ~iclkLast_reg;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  reg [2:0]  state_reg;
  reg [11:0] cnt_reg;
  reg [15:0] bitCnt_reg;
  reg [NBITS-1:0] shift_reg;
  reg [31:0] wake_reg;
  reg        modeLatched_reg;
  reg        sampleDue_reg;
  wire       tick;
  wire       shifting = (state_reg == S_SHIFT) && modeLatched_reg;
  // ext clock half period 2 cycles = 100 ns period, phases 50 ns
  sarc_clk_div #(.HALF(`SARC_EXT_HALF_CYC)) uDiv (
    .clk (clk),
    .rst (rst),
    .run (shifting),
    .tick(tick)
  );
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg         <= S_IDLE;
      cnt_reg           <= 12'h000;
      bitCnt_reg        <= 16'h0000;
      shift_reg         <= {NBITS{1'b0}};
      modeLatched_reg   <= 1'b1;
      sampleDue_reg     <= 1'b0;
      convReadSel       <= 1'b1;
      chipSelN          <= 1'b1;
      serialBitClockOut <= 1'b0;
      clockSourceSelect <= 1'b1;
      resultData        <= {NBITS{1'b0}};
      resultValid       <= 1'b0;
      hostIdle          <= 1'b0;
    end else begin
      resultValid   <= 1'b0;
      hostIdle      <= (state_reg == S_IDLE) && !wakeBusy && !analogSleep;
      sampleDue_reg <= 1'b0;
      // the data synchroniser lags the pin by two cycles, so a bit that stands
      // from a rising edge is taken one cycle after the falling edge that follows it
      if (sampleDue_reg)
        shift_reg <= {shift_reg[NBITS-2:0], dataSync_reg[1]};
      case (state_reg)
        S_IDLE: begin
          serialBitClockOut <= 1'b0;
          chipSelN          <= 1'b1;
          convReadSel       <= 1'b1;
          // chains need the shared external clock
          clockSourceSelect <= extMode | (CHAIN > 1);
          // a start that meets a sleep request is refused, so both never act at once
          if (startReq && !wakeBusy && !analogSleep && !sleepReq) begin
            modeLatched_reg <= extMode | (CHAIN > 1);
            chipSelN        <= 1'b0;
            convReadSel     <= 1'b0;
            cnt_reg         <= 12'h000;
            bitCnt_reg      <= 16'h0000;
            state_reg       <= S_CONV;
          end
        end
        S_CONV: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == `SARC_CONV_PULSE_CYC - 1) begin
            convReadSel <= 1'b1;
            cnt_reg     <= 12'h000;
            state_reg   <= S_WAITB;
          end
          // internal mode: sample previous result on converter clock rises
          if (!modeLatched_reg && iclkRise && bitCnt_reg < `SARC_INT_BITS) begin
            shift_reg  <= {shift_reg[NBITS-2:0], dataSync_reg[1]};
            bitCnt_reg <= bitCnt_reg + 16'h0001;
          end
        end
        S_WAITB: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (!modeLatched_reg && iclkRise && bitCnt_reg < `SARC_INT_BITS) begin
            shift_reg  <= {shift_reg[NBITS-2:0], dataSync_reg[1]};
            bitCnt_reg <= bitCnt_reg + 16'h0001;
          end
          // read after busy rises, or once the 4 * SARC_BUSY_MAX_CYC cycle timeout expires even if busy never rose
          if (busyRise || cnt_reg == 4 * `SARC_BUSY_MAX_CYC) begin
            cnt_reg   <= 12'h000;
            state_reg <= modeLatched_reg ? S_SETUP : S_DONE;
          end
        end
        S_SETUP: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == `SARC_BUSY_SETUP_CYC + `SARC_SEL_SETUP_CYC) begin
            bitCnt_reg <= 16'h0000;
            state_reg  <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (tick) begin
            serialBitClockOut <= ~serialBitClockOut;
            // data valid at each falling edge, sample then
            if (serialBitClockOut) begin
              sampleDue_reg <= 1'b1;
              bitCnt_reg    <= bitCnt_reg + 16'h0001;
              if (bitCnt_reg == NBITS - 1)
                state_reg <= S_DRAIN;
            end
          end
        end
        // clock parked low; wait for the last bit to come through the synchroniser
        S_DRAIN: begin
          if (sampleDue_reg)
            state_reg <= S_DONE;
        end
        S_DONE: begin
          serialBitClockOut <= 1'b0;
          chipSelN          <= 1'b1;
          resultData        <= shift_reg;
          resultValid       <= 1'b1;
          state_reg         <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // power-down and recovery wait
  // ****************************************************************
  // sleep only taken in idle so no unread result is lost
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      analogSleep    <= 1'b0;
      referenceSleep <= 1'b0;
      wakeBusy       <= 1'b0;
      wake_reg       <= 32'h00000000;
    end else begin
      if (state_reg == S_IDLE && sleepReq != analogSleep) begin
        analogSleep    <= sleepReq;
        referenceSleep <= sleepReq;
        if (!sleepReq) begin
          wakeBusy <= 1'b1;
          wake_reg <= WAKE_CYC;
        end
      end else if (wakeBusy) begin
        if (wake_reg <= 32'h00000001)
          wakeBusy <= 1'b0;
        wake_reg <= wake_reg - 32'h00000001;
      end
    end
  end
endmodule // sarc_host
`default_nettype wire

/* testbench/sarc_host_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// pin protocol checks on the host side
// ********
module sarc_host_sva #(
  parameter CHAIN = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic busyIn,
  input wire logic convReadSel,
  input wire logic chipSelN,
  input wire logic serialBitClockOut,
  input wire logic clockSourceSelect,
  input wire logic analogSleep,
  input wire logic wakeBusy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  AST_HI_PHASE: assert property (
    $rose(serialBitClockOut) |=> serialBitClockOut ##1 !serialBitClockOut)
    else $error("bit clock high phase too short");
  AST_LO_PHASE: assert property ($fell(serialBitClockOut) |=> !serialBitClockOut)
    else $error("bit clock low phase too short");
  AST_BUSY_SETUP: assert property ($rose(serialBitClockOut) |-> busyIn && $past(busyIn, 2))
    else $error("bit clock edge too close to busy or inside conversion");
  AST_CS_SETUP: assert property (
    $rose(chipSelN) |-> !serialBitClockOut ##1 !serialBitClockOut)
    else $error("bit clock rose too soon after deselect");
  AST_EXT_READ: assert property (serialBitClockOut |-> !chipSelN && convReadSel)
    else $error("bit clock outside a read window");
  AST_CHAIN_EXT: assert property (CHAIN > 1 |-> clockSourceSelect)
    else $error("chain left in internal clock mode");
  AST_WAKE: assert property ($fell(analogSleep) |-> ##[0:2] wakeBusy [*8])
    else $error("recovery wait missing after wake");
  AST_NO_START: assert property ((analogSleep || wakeBusy) |-> convReadSel)
    else $error("convert issued while asleep or recovering");
  cover property ($rose(serialBitClockOut));
  cover property ($rose(busyIn));
  cover property ($fell(analogSleep));
endmodule // sarc_host_sva
bind sarc_host sarc_host_sva #(.CHAIN(CHAIN)) u_sva (.clk(clk), .rst(rst), .busyIn(busyIn),
  .convReadSel(convReadSel), .chipSelN(chipSelN), .serialBitClockOut(serialBitClockOut),
  .clockSourceSelect(clockSourceSelect), .analogSleep(analogSleep), .wakeBusy(wakeBusy));
`default_nettype wire

/* testbench/sarc_adc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// converter model, external bit clock or its own internal bit clock (intMode)
// ********
module sarc_adc_model (
  input  wire logic        convReadSel,
  input  wire logic        chipSelN,
  input  wire logic        bitClk,
  input  wire logic        chainIn,
  input  wire logic        analogSleep,
  input  wire logic        intMode,
  input  wire logic [15:0] sample,
  output logic             busy,
  output logic             serialOut,
  output logic             intClk
);
  logic [15:0] shiftReg = 16'h0000;
  logic        firstEdge = 1'b1;
  logic        tagAtStart = 1'b0;
  initial busy = 1'b1;
  initial intClk = 1'b0;
  assign serialOut = shiftReg[15];
  always begin
    @(negedge convReadSel);
    #1;
    if (!chipSelN) begin
      #19 busy = 1'b0;
      tagAtStart = chainIn;
      if (intMode) begin
        // previous result leaves on the converter's own bit clock during conversion
        #151;
        repeat (16) begin
          intClk = 1'b1;
          #48 intClk = 1'b0;
          #41 shiftReg = {shiftReg[14:0], tagAtStart};
          #7;
        end
        #593 shiftReg = analogSleep ? ~sample : sample;
      end else begin
        #2280 shiftReg = analogSleep ? ~sample : sample;
      end
      firstEdge = 1'b1;
      #90 busy = 1'b1;
    end
  end
  // first edge keeps the msb so it is still there at the first falling edge
  always @(posedge bitClk) begin
    if (!chipSelN && convReadSel && busy) begin
      firstEdge <= 1'b0;
      if (!firstEdge) shiftReg <= {shiftReg[14:0], chainIn};
    end
  end
endmodule // sarc_adc_model
`default_nettype wire

/* testbench/tb_sarc_host.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// two chained converters read through the host
// ********
module tb_sarc_host;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        startReq = 1'b0;
  logic        extMode = 1'b1;
  logic        sleepReq = 1'b0;
  logic        tagIn = 1'b0;
  logic [15:0] sampleA = 16'h0000;
  logic [15:0] sampleB = 16'h0000;
  wire         busyB, serA, serB, convReadSel, chipSelN, bitClk, clkSel;
  wire         analogSleep, referenceSleep, resultValid, hostIdle, wakeBusy;
  wire  [31:0] resultData;
  wire         busyI, serI, crsI, csI, bclkI, iclkI, clkSelI, idleI;
  wire  [15:0] resultI;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  always #12.5 clk = ~clk;
  sarc_host #(.CHAIN(2), .WAKE_CYC(10)) dut_u (.clk(clk), .rst(rst), .startReq(startReq),
    .extMode(extMode), .sleepReq(sleepReq), .busyIn(busyB), .serialResultLine(serB),
    .serialBitClockIn(1'b0), .convReadSel(convReadSel), .chipSelN(chipSelN),
    .serialBitClockOut(bitClk), .clockSourceSelect(clkSel), .analogSleep(analogSleep),
    .referenceSleep(referenceSleep), .resultData(resultData), .resultValid(resultValid),
    .hostIdle(hostIdle), .wakeBusy(wakeBusy));
  sarc_adc_model up_u (.convReadSel(convReadSel), .chipSelN(chipSelN), .bitClk(bitClk),
    .chainIn(tagIn), .analogSleep(analogSleep), .intMode(~clkSel), .sample(sampleA),
    .busy(), .serialOut(serA), .intClk());
  sarc_adc_model dn_u (.convReadSel(convReadSel), .chipSelN(chipSelN), .bitClk(bitClk),
    .chainIn(serA), .analogSleep(analogSleep), .intMode(~clkSel), .sample(sampleB),
    .busy(busyB), .serialOut(serB), .intClk());
  // single converter on a host of its own: the only place internal clock mode can run
  sarc_host #(.CHAIN(1), .WAKE_CYC(10)) dut_i (.clk(clk), .rst(rst), .startReq(startReq),
    .extMode(extMode), .sleepReq(sleepReq), .busyIn(busyI), .serialResultLine(serI),
    .serialBitClockIn(iclkI), .convReadSel(crsI), .chipSelN(csI),
    .serialBitClockOut(bclkI), .clockSourceSelect(clkSelI), .analogSleep(),
    .referenceSleep(), .resultData(resultI), .resultValid(),
    .hostIdle(idleI), .wakeBusy());
  sarc_adc_model one_u (.convReadSel(crsI), .chipSelN(csI), .bitClk(bclkI),
    .chainIn(tagIn), .analogSleep(analogSleep), .intMode(~clkSelI), .sample(sampleA),
    .busy(busyI), .serialOut(serI), .intClk(iclkI));
  task automatic close_out;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic run_conv(input logic [15:0] a, input logic [15:0] b, input logic tag,
                          input logic chkI, input logic [15:0] expI);
    int n;
    sampleA = a;
    sampleB = b;
    tagIn = tag;
    for (n = 0; n < 100 && (hostIdle !== 1'b1 || idleI !== 1'b1); n++) tick(1);
    startReq = 1'b1;
    tick(1);
    startReq = 1'b0;
    for (n = 0; n < 800 && resultValid !== 1'b1; n++) tick(1);
    check("resultData", {b, a}, resultData);
    // the single host finishes first; its word stands until its next result
    if (chkI) check("resultData single", {16'h0000, expI}, {16'h0000, resultI});
  endtask
  task automatic t_chain;
    run_conv(16'h8001, 16'h7ffe, 1'b1, 1'b1, 16'h8001);
    run_conv(16'ha5c3, 16'h3c5a, 1'b0, 1'b1, 16'ha5c3);
  endtask
  // internal mode reads the previous word, so only the second read is known
  task automatic t_mode;
    extMode = 1'b0;
    run_conv(16'h0f0f, 16'hf0f0, 1'b1, 1'b0, 16'h0000);
    run_conv(16'h5a5a, 16'h0ff0, 1'b0, 1'b1, 16'h0f0f);
    check("clock source", 32'h1, {31'h0, clkSel});
    check("clock source single", 32'h0, {31'h0, clkSelI});
    extMode = 1'b1;
  endtask
  task automatic t_sleep;
    sleepReq = 1'b1;
    tick(5);
    check("sleep pins", 32'h3, {30'h0, analogSleep, referenceSleep});
    startReq = 1'b1;
    tick(1);
    startReq = 1'b0;
    tick(5);
    check("select in sleep", 32'h1, {31'h0, chipSelN});
    sleepReq = 1'b0;
    tick(3);
    check("wake wait", 32'h1, {31'h0, wakeBusy});
    run_conv(16'h1234, 16'hfedc, 1'b1, 1'b1, 16'h1234);
  endtask
  // ceiling sized for five reads of about 250 cycles each, with ample margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    tick(3);
    rst = 1'b0;
    tick(1);
    t_chain();
    t_mode();
    t_sleep();
    close_out();
  end
endmodule // tb_sarc_host
`default_nettype wire
